// file: rtl/shs_pkg.sv
package shs_pkg;

  // ==========================================================================
  // i2c addressing
  // ==========================================================================
  localparam logic [5:0] I2C_ADDR_HI = 6'h3B;
  localparam logic [3:0] BYTE_BITS = 4'h8;

  // ==========================================================================
  // register map
  // ==========================================================================
  localparam logic [7:0] TRIM_BASE = 8'h30;
  localparam logic [7:0] TRIM_LAST = 8'h57;
  localparam logic [7:0] CMD_ADDR = 8'h7E;
  localparam logic [7:0] CMD_READ_VALUE = 8'h00;
  localparam logic [7:0] CMD_NOP = 8'h00;
  localparam logic [7:0] CMD_FLUSH = 8'hB0;
  localparam logic [7:0] CMD_SOFTRESET = 8'hB6;
  localparam logic [7:0] CFG_BASE = 8'h10;
  localparam logic [7:0] CFG_DEPTH = 8'h10;
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam logic [7:0] UNMAPPED_VALUE = 8'h00;
  // trim fill value is arbitrary
  localparam logic [7:0] TRIM_SEED = 8'h5A;

  // ==========================================================================
  // synchroniser lanes: 0 clock, 1 data, 2 select, 3 strap, 4 byte toggle
  // ==========================================================================
  localparam int SYNC_W = 5;
  localparam logic [4:0] SYNC_RESET = 5'h07;

  // ==========================================================================
  // i2c engine states
  // ==========================================================================
  typedef enum logic [6:0] {
    I2C_IDLE = 7'h01,
    I2C_ADDR = 7'h02,
    I2C_AACK = 7'h04,
    I2C_WR = 7'h08,
    I2C_WACK = 7'h10,
    I2C_RD = 7'h20,
    I2C_MACK = 7'h40
  } shs_i2c_state_t;

  function automatic logic shs_addr_match(input logic [6:0] addr,
                                          input logic strap);
    shs_addr_match = (addr == {I2C_ADDR_HI, strap});
  endfunction : shs_addr_match

endpackage : shs_pkg

// file: rtl/shs_sync.sv
`timescale 1ns/1ps
module shs_sync (
  input wire logic clk,
  input wire logic rst,
  input wire logic [shs_pkg::SYNC_W-1:0] d,
  output logic [shs_pkg::SYNC_W-1:0] q
);
  import shs_pkg::*;

  logic [SYNC_W-1:0] meta_reg;

  // ==========================================================================
  // two flip-flop level synchroniser
  // ==========================================================================
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_reg <= SYNC_RESET;
      q <= SYNC_RESET;
    end else begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end

endmodule : shs_sync

// file: rtl/shs_regfile.sv
`timescale 1ns/1ps
module shs_regfile (
  input wire logic clk,
  input wire logic rst,
  input wire logic wr_en,
  input wire logic [7:0] wr_addr,
  input wire logic [7:0] wr_data,
  input wire logic [7:0] rd_addr,
  output logic [7:0] rd_data,
  output logic flush_pulse,
  output logic soft_reset_pulse
);
  import shs_pkg::*;

  logic [7:0] cfg_reg [16];
  logic cmd_wr;

  function automatic logic in_cfg(input logic [7:0] a);
    in_cfg = (a >= CFG_BASE) && (a < 8'(CFG_BASE + CFG_DEPTH));
  endfunction : in_cfg

  function automatic logic [3:0] cfg_idx(input logic [7:0] a);
    cfg_idx = 4'(a - CFG_BASE);
  endfunction : cfg_idx

  assign cmd_wr = wr_en && (wr_addr == CMD_ADDR);

  // ==========================================================================
  // user configuration storage
  // ==========================================================================
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < 16; i++) begin
        cfg_reg[i] <= CFG_RESET;
      end
    end else if (cmd_wr && (wr_data == CMD_SOFTRESET)) begin
      for (int i = 0; i < 16; i++) begin
        cfg_reg[i] <= CFG_RESET; // [R15]
      end
    end else if (wr_en && in_cfg(wr_addr)) begin
      cfg_reg[cfg_idx(wr_addr)] <= wr_data;
    end
  end

  // ==========================================================================
  // command decode, undefined codes ignored
  // ==========================================================================
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      flush_pulse <= 1'b0;
      soft_reset_pulse <= 1'b0;
    end else begin
      flush_pulse <= cmd_wr && (wr_data == CMD_FLUSH); // [R14] [R18]
      soft_reset_pulse <= cmd_wr && (wr_data == CMD_SOFTRESET); // [R15]
    end
  end

  // ==========================================================================
  // read decode
  // ==========================================================================
  always_comb begin
    rd_data = UNMAPPED_VALUE;
    if (in_cfg(rd_addr)) begin
      rd_data = cfg_reg[cfg_idx(rd_addr)];
    end else if ((rd_addr >= TRIM_BASE) && (rd_addr <= TRIM_LAST)) begin
      rd_data = 8'(TRIM_SEED + (rd_addr - TRIM_BASE));
    end else if (rd_addr == CMD_ADDR) begin
      rd_data = CMD_READ_VALUE; // [R13]
    end
  end

endmodule : shs_regfile

// file: rtl/shs_serial_slave.sv
// Functional notes
// R01 - slave only, never drives serial clock
// R02 - i2c works at every bus rate
// R03 - spi modes 00 and 11, three/four wire
// R04 - burst write uses address/data pairs
// R05 - burst read auto-increments address
// R06 - select high gives i2c, low spi
// R07 - select low once locks spi mode
// R08 - host holds select high for i2c
// R09 - i2c address upper bits 111011
// R10 - address lsb follows strap pin live
// R11 - board drives strap to defined level
// R12 - i2c data line driven low only
// R13 - command register reads zero, write-only
// R14 - code B0 flushes sample buffer
// R15 - code B6 resets user configuration
// R16 - i2c write: address, pairs, stop
// R17 - i2c read: set address, readdress, stream
// R18 - command acts after byte, unknown ignored
`timescale 1ns/1ps
module shs_serial_slave (
  input wire logic clk,
  input wire logic rst,
  input wire logic serial_clk,
  input wire logic select_pin_low,
  input wire logic data_pin_in,
  input wire logic address_strap_pin,
  input wire logic spi_three_wire,
  output logic data_pin_out,
  output logic data_pin_oe,
  output logic strap_pin_out,
  output logic strap_pin_oe,
  output logic spi_mode,
  output logic fifo_flush,
  output logic soft_reset
);
  import shs_pkg::*;

  // ==========================================================================
  // declarations
  // ==========================================================================
  logic spi_arst;
  logic [2:0] spi_bit_reg;
  logic [6:0] spi_sh_reg;
  logic spi_first_reg;
  logic spi_rd_reg;
  logic [7:0] spi_rx_reg;
  logic spi_tgl_reg;
  logic [7:0] spi_tx_reg;
  logic spi_doe_reg;
  logic spi_soe_reg;

  logic [SYNC_W-1:0] sync_d;
  logic [SYNC_W-1:0] sync_q;
  logic scl_s;
  logic sda_s;
  logic cs_s;
  logic strap_s;
  logic tgl_s;
  logic scl_d_reg;
  logic sda_d_reg;
  logic tgl_d_reg;

  logic spi_mode_reg;
  logic spi3_reg;
  logic [7:0] spi_ptr_reg;
  logic spi_ctrl_reg;
  logic spi_read_reg;
  logic [7:0] tx_word_reg;
  logic spi_evt;
  logic spi_wr;

  shs_i2c_state_t i2c_st_reg;
  logic [3:0] i2c_cnt_reg;
  logic [7:0] i2c_sh_reg;
  logic [7:0] i2c_tx_reg;
  logic i2c_oe_reg;
  logic i2c_rw_reg;
  logic i2c_nack_reg;
  logic i2c_exp_reg;
  logic [7:0] i2c_ptr_reg;
  logic scl_rise;
  logic scl_fall;
  logic i2c_start;
  logic i2c_stop;
  logic i2c_wr;

  logic wr_en;
  logic [7:0] wr_addr;
  logic [7:0] wr_data;
  logic [7:0] rd_addr;
  logic [7:0] rd_data;

  // ==========================================================================
  // spi link domain: receive on rising edge, all but the byte hand-off reset while deselected
  // ==========================================================================
  // serial_clk is only ever an input here [R01]
  assign spi_arst = rst | select_pin_low;

  always_ff @(posedge serial_clk or posedge spi_arst) begin
    if (spi_arst) begin
      spi_bit_reg <= 3'h0;
      spi_sh_reg <= 7'h00;
      spi_first_reg <= 1'b1;
      spi_rd_reg <= 1'b0;
    end else begin
      spi_bit_reg <= 3'(spi_bit_reg + 3'h1); // [R03]
      spi_sh_reg <= {spi_sh_reg[5:0], data_pin_in};
      if (spi_bit_reg == 3'h7 && spi_first_reg) begin
        spi_first_reg <= 1'b0;
        spi_rd_reg <= spi_sh_reg[6];
      end
    end
  end

  // byte hand-off survives deselect so the last byte is never lost
  always_ff @(posedge serial_clk or posedge rst) begin
    if (rst) begin
      spi_rx_reg <= 8'h00;
      spi_tgl_reg <= 1'b0;
    end else if (!select_pin_low && spi_bit_reg == 3'h7) begin
      spi_rx_reg <= {spi_sh_reg, data_pin_in};
      spi_tgl_reg <= ~spi_tgl_reg;
    end
  end

  // ==========================================================================
  // spi link domain: transmit on falling edge
  // ==========================================================================
  // load at byte start covers both idle polarities [R03]
  always_ff @(negedge serial_clk or posedge spi_arst) begin
    if (spi_arst) begin
      spi_tx_reg <= 8'h00;
      spi_doe_reg <= 1'b0;
      spi_soe_reg <= 1'b0;
    end else begin
      if (spi_bit_reg == 3'h0) begin
        spi_tx_reg <= tx_word_reg;
      end else begin
        spi_tx_reg <= {spi_tx_reg[6:0], 1'b0};
      end
      spi_doe_reg <= spi3_reg & spi_rd_reg; // [R03]
      spi_soe_reg <= ~spi3_reg; // [R03]
    end
  end

  // ==========================================================================
  // pin synchronisers
  // ==========================================================================
  assign sync_d = {spi_tgl_reg, address_strap_pin, select_pin_low,
                   data_pin_in, serial_clk};

  shs_sync u_sync (
    .clk(clk),
    .rst(rst),
    .d(sync_d),
    .q(sync_q)
  );

  assign scl_s = sync_q[0];
  assign sda_s = sync_q[1];
  assign cs_s = sync_q[2];
  assign strap_s = sync_q[3]; // [R10] [R11]
  assign tgl_s = sync_q[4];

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
      tgl_d_reg <= 1'b0;
    end else begin
      scl_d_reg <= scl_s;
      sda_d_reg <= sda_s;
      tgl_d_reg <= tgl_s;
    end
  end

  // ==========================================================================
  // interface selection lock, cleared only by reset
  // ==========================================================================
  // select sync resets high so a held-high select keeps i2c [R08]
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      spi_mode_reg <= 1'b0;
    end else if (!cs_s) begin
      spi_mode_reg <= 1'b1; // [R06] [R07]
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      spi3_reg <= 1'b0;
    end else begin
      spi3_reg <= spi_three_wire;
    end
  end

  // ==========================================================================
  // spi byte engine
  // ==========================================================================
  assign spi_evt = tgl_s ^ tgl_d_reg;
  assign spi_wr = spi_evt & spi_mode_reg & ~spi_read_reg & ~spi_ctrl_reg;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      spi_ptr_reg <= 8'h00;
      spi_ctrl_reg <= 1'b1;
      spi_read_reg <= 1'b0;
    end else if (spi_evt) begin
      if (spi_read_reg) begin
        spi_ptr_reg <= 8'(spi_ptr_reg + 8'h01); // [R05]
      end else if (spi_ctrl_reg) begin
        spi_ptr_reg <= {1'b0, spi_rx_reg[6:0]};
        spi_read_reg <= spi_rx_reg[7];
        spi_ctrl_reg <= 1'b0;
      end else begin
        spi_ctrl_reg <= 1'b1; // [R04]
      end
    end else if (cs_s) begin
      spi_ctrl_reg <= 1'b1;
      spi_read_reg <= 1'b0;
    end
  end

  // word is stable long before the link samples it at byte start
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_word_reg <= 8'h00;
    end else begin
      tx_word_reg <= rd_data;
    end
  end

  // ==========================================================================
  // i2c bus conditions, oversampled for every bus rate
  // ==========================================================================
  assign scl_rise = scl_s & ~scl_d_reg; // [R02]
  assign scl_fall = ~scl_s & scl_d_reg;
  assign i2c_start = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
  assign i2c_stop = scl_s & scl_d_reg & ~sda_d_reg & sda_s;
  assign i2c_wr = scl_fall & (i2c_st_reg == I2C_WR) &
                  (i2c_cnt_reg == BYTE_BITS) & ~i2c_exp_reg;

  // ==========================================================================
  // i2c engine
  // ==========================================================================
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      i2c_st_reg <= I2C_IDLE;
      i2c_cnt_reg <= 4'h0;
      i2c_sh_reg <= 8'h00;
      i2c_tx_reg <= 8'h00;
      i2c_oe_reg <= 1'b0;
      i2c_rw_reg <= 1'b0;
      i2c_nack_reg <= 1'b0;
      i2c_exp_reg <= 1'b1;
      i2c_ptr_reg <= 8'h00;
    end else if (spi_mode_reg) begin
      i2c_st_reg <= I2C_IDLE; // [R07]
      i2c_oe_reg <= 1'b0;
    end else if (i2c_start) begin
      i2c_st_reg <= I2C_ADDR; // [R17]
      i2c_cnt_reg <= 4'h0;
      i2c_oe_reg <= 1'b0;
    end else if (i2c_stop) begin
      i2c_st_reg <= I2C_IDLE; // [R16]
      i2c_oe_reg <= 1'b0;
    end else if (scl_rise) begin
      case (i2c_st_reg)
        I2C_ADDR, I2C_WR: begin
          i2c_sh_reg <= {i2c_sh_reg[6:0], sda_s};
          i2c_cnt_reg <= 4'(i2c_cnt_reg + 4'h1);
        end
        I2C_RD: begin
          i2c_cnt_reg <= 4'(i2c_cnt_reg + 4'h1);
        end
        I2C_MACK: begin
          i2c_nack_reg <= sda_s; // [R17]
        end
        default: begin
        end
      endcase
    end else if (scl_fall) begin
      case (i2c_st_reg)
        I2C_ADDR: begin
          if (i2c_cnt_reg == BYTE_BITS) begin
            if (shs_addr_match(i2c_sh_reg[7:1], strap_s)) begin // [R09]
              i2c_oe_reg <= 1'b1; // [R10]
              i2c_rw_reg <= i2c_sh_reg[0];
              i2c_st_reg <= I2C_AACK;
            end else begin
              i2c_st_reg <= I2C_IDLE;
            end
          end
        end
        I2C_AACK: begin
          i2c_cnt_reg <= 4'h0;
          if (i2c_rw_reg) begin
            i2c_tx_reg <= rd_data;
            i2c_oe_reg <= ~rd_data[7]; // [R12]
            i2c_st_reg <= I2C_RD;
          end else begin
            i2c_oe_reg <= 1'b0;
            i2c_exp_reg <= 1'b1; // [R16]
            i2c_st_reg <= I2C_WR;
          end
        end
        I2C_WR: begin
          if (i2c_cnt_reg == BYTE_BITS) begin
            i2c_oe_reg <= 1'b1;
            i2c_st_reg <= I2C_WACK;
            i2c_exp_reg <= ~i2c_exp_reg; // [R04]
            if (i2c_exp_reg) begin
              i2c_ptr_reg <= i2c_sh_reg; // [R17]
            end
          end
        end
        I2C_WACK: begin
          i2c_oe_reg <= 1'b0;
          i2c_cnt_reg <= 4'h0;
          i2c_st_reg <= I2C_WR;
        end
        I2C_RD: begin
          if (i2c_cnt_reg == BYTE_BITS) begin
            i2c_oe_reg <= 1'b0;
            i2c_ptr_reg <= 8'(i2c_ptr_reg + 8'h01); // [R05]
            i2c_st_reg <= I2C_MACK;
          end else begin
            i2c_tx_reg <= {i2c_tx_reg[6:0], 1'b0};
            i2c_oe_reg <= ~i2c_tx_reg[6]; // [R12]
          end
        end
        I2C_MACK: begin
          if (i2c_nack_reg) begin
            i2c_st_reg <= I2C_IDLE; // [R17]
          end else begin
            i2c_cnt_reg <= 4'h0;
            i2c_tx_reg <= rd_data;
            i2c_oe_reg <= ~rd_data[7];
            i2c_st_reg <= I2C_RD;
          end
        end
        default: begin
          i2c_st_reg <= I2C_IDLE;
        end
      endcase
    end
  end

  // ==========================================================================
  // register file access
  // ==========================================================================
  assign wr_en = spi_mode_reg ? spi_wr : i2c_wr; // [R18]
  assign wr_addr = spi_mode_reg ? spi_ptr_reg : i2c_ptr_reg; // [R04]
  assign wr_data = spi_mode_reg ? spi_rx_reg : i2c_sh_reg;
  assign rd_addr = spi_mode_reg ? spi_ptr_reg : i2c_ptr_reg;

  shs_regfile u_regfile (
    .clk(clk),
    .rst(rst),
    .wr_en(wr_en),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .rd_addr(rd_addr),
    .rd_data(rd_data),
    .flush_pulse(fifo_flush),
    .soft_reset_pulse(soft_reset)
  );

  // ==========================================================================
  // pins: i2c only ever pulls low, spi tx reset to zero while deselected
  // ==========================================================================
  assign data_pin_out = spi_tx_reg[7]; // [R12]
  assign data_pin_oe = spi_doe_reg | i2c_oe_reg;
  assign strap_pin_out = spi_tx_reg[7];
  assign strap_pin_oe = spi_soe_reg;
  assign spi_mode = spi_mode_reg;

endmodule : shs_serial_slave

// file: tb/shs_serial_slave_properties.sv
`timescale 1ns/1ps
// ====================
// port checker
// ====================
module shs_serial_slave_chk (
  input wire logic clk,
  input wire logic rst,
  input wire logic select_pin_low,
  input wire logic spi_three_wire,
  input wire logic data_pin_out,
  input wire logic data_pin_oe,
  input wire logic strap_pin_oe,
  input wire logic spi_mode,
  input wire logic fifo_flush,
  input wire logic soft_reset
);
  default clocking dc @(posedge clk);
  endclocking
  default disable iff (rst);
  property p_od_low;
    data_pin_oe && select_pin_low && !spi_mode |-> !data_pin_out;
  endproperty
  a_od_low: assert property (p_od_low) else $error("data high");
  property p_lock_set;
    !select_pin_low |-> ##[0:5] spi_mode;
  endproperty
  a_lock_set: assert property (p_lock_set) else $error("no lock");
  property p_lock_hold;
    spi_mode |=> spi_mode;
  endproperty
  a_lock_hold: assert property (p_lock_hold) else $error("lock");
  property p_spi_quiet;
    spi_mode && select_pin_low && $past(select_pin_low, 6)
      |-> !data_pin_oe && !strap_pin_oe;
  endproperty
  a_spi_quiet: assert property (p_spi_quiet) else $error("pin");
  property p_no_strap;
    !spi_mode |-> !strap_pin_oe;
  endproperty
  a_no_strap: assert property (p_no_strap) else $error("strap");
  property p_three;
    spi_three_wire |-> !strap_pin_oe;
  endproperty
  a_three: assert property (p_three) else $error("3-wire");
  property p_flush;
    fifo_flush |-> !soft_reset ##1 !fifo_flush;
  endproperty
  a_flush: assert property (p_flush) else $error("flush");
  property p_sreset;
    soft_reset |=> !soft_reset;
  endproperty
  a_sreset: assert property (p_sreset) else $error("sreset");
  c_flush: cover property (fifo_flush);
  c_sreset: cover property (soft_reset);
  c_lock: cover property ($rose(spi_mode));
endmodule : shs_serial_slave_chk

bind shs_serial_slave shs_serial_slave_chk shs_serial_slave_chk_inst (
  .clk(clk), .rst(rst), .select_pin_low(select_pin_low),
  .spi_three_wire(spi_three_wire), .data_pin_out(data_pin_out),
  .data_pin_oe(data_pin_oe), .strap_pin_oe(strap_pin_oe),
  .spi_mode(spi_mode), .fifo_flush(fifo_flush), .soft_reset(soft_reset)
);

// file: tb/shs_master_model.sv
`timescale 1ns/1ps
// ====================
// serial bus master
// ====================
module shs_master_model (
  input wire logic three_wire,
  input wire logic data_wire,
  input wire logic strap_wire,
  output logic sclk,
  output logic sel_level,
  output logic m_drv,
  output logic m_val
);
  localparam int H = 52;
  int q = 60;
  logic cpol_r = 1'b0;
  initial begin
    sclk = 1'b1;
    sel_level = 1'b1;
    m_drv = 1'b0;
    m_val = 1'b0;
  end
  // open drain, only pulls low
  task automatic i2c_start();
    m_val = 1'b0;
    m_drv = 1'b0;
    #q sclk = 1'b1;
    #q m_drv = 1'b1;
    #q sclk = 1'b0;
    #q;
  endtask : i2c_start
  task automatic i2c_stop();
    m_drv = 1'b1;
    #q sclk = 1'b1;
    #q m_drv = 1'b0;
    #q;
  endtask : i2c_stop
  // ninth bit: 1 releases for ack, 0 is master ack
  task automatic i2c_byte(input logic [7:0] b, input logic nine,
                          output logic [7:0] r, output logic ack);
    logic [8:0] w;
    w = {b, nine};
    for (int i = 8; i >= 0; i--) begin
      m_drv = !w[i];
      #q sclk = 1'b1;
      #q;
      if (i > 0) r[i-1] = data_wire;
      else ack = !data_wire;
      #q sclk = 1'b0;
      #q;
    end
  endtask : i2c_byte
  task automatic spi_begin(input logic cpol);
    cpol_r = cpol;
    sclk = cpol;
    #H sel_level = 1'b0;
    #H;
  endtask : spi_begin
  // drive before rise, sample at rise, msb first
  task automatic spi_byte(input logic [7:0] b, input logic rel,
                          output logic [7:0] r);
    for (int i = 7; i >= 0; i--) begin
      sclk = 1'b0;
      m_drv = !rel;
      m_val = b[i];
      #H sclk = 1'b1;
      r[i] = three_wire ? data_wire : strap_wire;
      #H;
    end
  endtask : spi_byte
  task automatic spi_end();
    m_drv = 1'b0;
    sclk = cpol_r;
    #H sel_level = 1'b1;
    #H;
  endtask : spi_end
endmodule : shs_master_model

// file: tb/testbench.sv
`timescale 1ns/1ps
// ====================
// testbench
// ====================
module testbench;
  import shs_pkg::*;
  typedef struct packed {logic [7:0] ra, wd, rd;} shs_row_t;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic strap_lvl = 1'b0;
  logic three = 1'b0;
  logic sclk, sel_level, m_drv, m_val, data_wire, strap_wire;
  logic sclk_m, sel_m, drv_m, val_m;
  logic data_pin_out, data_pin_oe, strap_pin_out, strap_pin_oe;
  logic spi_mode, fifo_flush, soft_reset, a;
  logic [7:0] r;
  logic [6:0] dev = 7'h76;
  int error_cnt = 0;
  int num_checks = 0;
  int flush_cnt = 0;
  int sreset_cnt = 0;
  shs_row_t rows [6];
  logic [7:0] seq [6];
  logic [6:0] addrs [3];
  always #2 clk = ~clk;
  // link pins move 1 ns after the model, never on a clk edge
  assign #1 {sclk, sel_level, m_drv, m_val} =
    {sclk_m, sel_m, drv_m, val_m};
  // pull-up on the data line
  assign data_wire = !((data_pin_oe && !data_pin_out) ||
                       (m_drv && !m_val));
  assign strap_wire = strap_pin_oe ? strap_pin_out : strap_lvl;
  always @(posedge clk) begin
    if (fifo_flush === 1'b1) flush_cnt++;
    if (soft_reset === 1'b1) sreset_cnt++;
  end
  shs_serial_slave shs_serial_slave_inst (
    .clk(clk), .rst(rst), .serial_clk(sclk),
    .select_pin_low(sel_level), .data_pin_in(data_wire),
    .address_strap_pin(strap_wire), .spi_three_wire(three),
    .data_pin_out(data_pin_out), .data_pin_oe(data_pin_oe),
    .strap_pin_out(strap_pin_out), .strap_pin_oe(strap_pin_oe),
    .spi_mode(spi_mode), .fifo_flush(fifo_flush), .soft_reset(soft_reset)
  );
  shs_master_model shs_master_model_inst (
    .three_wire(three), .data_wire(data_wire), .strap_wire(strap_wire),
    .sclk(sclk_m), .sel_level(sel_m), .m_drv(drv_m), .m_val(val_m)
  );
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: seen %h exp %h", $time, seen, exp);
    end
  endtask : check
  task automatic report_and_stop();
    if (error_cnt == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : report_and_stop
  task automatic bus_byte(input logic [7:0] b, input logic nine);
    shs_master_model_inst.i2c_byte(b, nine, r, a);
  endtask : bus_byte
  task automatic i2c_go(input logic rw);
    shs_master_model_inst.i2c_start();
    bus_byte({dev, rw}, 1'b1);
  endtask : i2c_go
  task automatic wr_reg(input logic [7:0] ra, input logic [7:0] wd);
    i2c_go(1'b0);
    bus_byte(ra, 1'b1);
    bus_byte(wd, 1'b1);
    shs_master_model_inst.i2c_stop();
  endtask : wr_reg
  task automatic rd_open(input logic [7:0] ra);
    i2c_go(1'b0);
    bus_byte(ra, 1'b1);
    i2c_go(1'b1);
    check({7'h00, a}, 8'h01);
  endtask : rd_open
  task automatic rd_next(input logic last, input logic [7:0] exp);
    bus_byte(8'hFF, last);
    check(r, exp);
    if (last) shs_master_model_inst.i2c_stop();
  endtask : rd_next
  task automatic spi_b(input logic [7:0] b, input logic rel);
    shs_master_model_inst.spi_byte(b, rel, r);
  endtask : spi_b
  initial begin
    repeat (90000) @(posedge clk);
    error_cnt++;
    report_and_stop();
  end
  initial begin
    rows[0] = '{8'h10, 8'hA5, 8'hA5};
    rows[1] = '{8'h1F, 8'h3C, 8'h3C};
    rows[2] = '{TRIM_BASE, 8'hFF, TRIM_SEED};
    rows[3] = '{TRIM_LAST, 8'h00, TRIM_SEED + 8'h27};
    rows[4] = '{CMD_ADDR, CMD_NOP, 8'h00};
    rows[5] = '{8'h20, 8'h77, 8'h00};
    seq = '{8'h11, 8'hC1, 8'h12, 8'hC2, CMD_ADDR, CMD_FLUSH};
    addrs = '{7'h76, 7'h77, 7'h37};
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    foreach (rows[i]) begin
      wr_reg(rows[i].ra, rows[i].wd);
      rd_open(rows[i].ra);
      rd_next(1'b1, rows[i].rd);
    end
    i2c_go(1'b0);
    foreach (seq[i]) bus_byte(seq[i], 1'b1);
    shs_master_model_inst.i2c_stop();
    check(8'(flush_cnt), 8'h01);
    rd_open(8'h11);
    rd_next(1'b0, 8'hC1);
    rd_next(1'b0, 8'hC2);
    rd_next(1'b1, 8'h00);
    rd_open(8'h56);
    rd_next(1'b0, TRIM_SEED + 8'h26);
    rd_next(1'b0, TRIM_SEED + 8'h27);
    rd_next(1'b1, 8'h00);
    wr_reg(CMD_ADDR, 8'h55);
    check(8'(flush_cnt + sreset_cnt), 8'h01);
    wr_reg(CMD_ADDR, CMD_SOFTRESET);
    check(8'(sreset_cnt), 8'h01);
    rd_open(8'h11);
    rd_next(1'b1, CFG_RESET);
    @(posedge clk);
    strap_lvl <= 1'b1;
    foreach (addrs[i]) begin
      dev = addrs[i];
      i2c_go(1'b0);
      shs_master_model_inst.i2c_stop();
      check({7'h00, a}, {7'h00, addrs[i] == {I2C_ADDR_HI, 1'b1}});
    end
    dev = 7'h77;
    shs_master_model_inst.q = 624;
    wr_reg(8'h14, 8'h3E);
    shs_master_model_inst.q = 60;
    rd_open(8'h14);
    rd_next(1'b1, 8'h3E);
    for (int k = 0; k < 4; k++) begin
      @(posedge clk);
      three <= k[1];
      @(posedge clk);
      shs_master_model_inst.spi_begin(k[0]);
      spi_b(8'h12, 1'b0);
      spi_b(8'h20 + 8'(k), 1'b0);
      spi_b(8'h13, 1'b0);
      spi_b(8'h60 + 8'(k), 1'b0);
      shs_master_model_inst.spi_end();
      check({7'h00, spi_mode}, 8'h01);
      shs_master_model_inst.spi_begin(k[0]);
      spi_b(8'h92, 1'b0);
      spi_b(8'hFF, 1'b1);
      check(r, 8'h20 + 8'(k));
      spi_b(8'hFF, 1'b1);
      check(r, 8'h60 + 8'(k));
      shs_master_model_inst.spi_end();
    end
    i2c_go(1'b0);
    shs_master_model_inst.i2c_stop();
    check({7'h00, a}, 8'h00);
    @(posedge clk);
    rst <= 1'b1;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    check({7'h00, spi_mode}, 8'h00);
    rd_open(8'h12);
    rd_next(1'b1, CFG_RESET);
    report_and_stop();
  end
endmodule : testbench
